//--- core/line_monitor.v
// Purpose: line timing checker, bus-free monitor and start pulse driver
// Assumes: APB slave, byte address = 4 x register index
// Notes: open-drain line, enable high while pulling low
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "line_monitor_map.vh"
module line_monitor (
  input wire clk_in, // 125 MHz clock
  input wire reset_in, // Synchronous reset, active high
  input wire psel_in, // APB select
  input wire penable_in, // APB enable
  input wire pwrite_in, // APB direction
  input wire [31:0] paddr_in, // APB byte address
  input wire [31:0] pwdata_in, // APB write data
  output reg [31:0] prdata_out, // APB read data
  output reg pready_out, // APB ready
  output reg pslverr_out, // APB error on unmapped address
  input wire line_in, // Shared line level
  output reg line_oe_out, // Pull line low
  output reg line_o_out, // Driven level, always low
  input wire start_req_in, // Start a start pulse
  output reg frame_abort_out, // Pulse: transfer aborted
  output reg rx_idle_out, // Pulse: receiver back to idle
  output reg irq_out // Level interrupt
);
  // Idle and low states of start pulse engine
  localparam S_IDLE = 1'b0;
  localparam S_LOW = 1'b1;

  reg [7:0] clock_prescaler;
  reg [7:0] tx_free_time;
  reg [7:0] min_edge_gap;
  reg [7:0] low_timeout_limit;
  reg [7:0] rx_free_time;
  reg [7:0] tx_start_low_duty;
  reg tx_free_irq_en;
  reg rx_free_irq_en;
  reg prescale_resolution;
  reg tx_bus_free_flag;
  reg rx_bus_free_flag;
  reg tx_free_irq_flag;
  reg rx_free_irq_flag;
  reg start_pulse_error;
  reg line_error_flag;
  reg timeout_flag;
  reg [`ST_WIDTH-1:0] irq_mask;
  reg [7:0] bit_period;
  reg [15:0] gap_count;
  reg [7:0] low_count;
  reg [3:0] bits_done;
  reg [7:0] bit_count;
  reg seen_fall;
  reg [10:0] high_count;
  reg [10:0] tx_free_count;
  reg state;
  reg [7:0] duty_count;
  wire time_unit;
  wire level;
  wire fall;
  wire rise;
  wire [15:0] idx;
  wire acc;
  wire wr;
  wire rd;
  wire mapped;
  wire wr_bfc;
  wire wr_st;
  wire [7:0] wd;
  wire [7:0] bfc_read;
  wire [`ST_WIDTH-1:0] status;
  wire rx_free_hit;
  wire tx_free_hit;
  wire gap_short;
  wire timeout_fire;
  reg [7:0] next_rdata;

  // Compare count against 8 x value, zero value never hits
  function free_hit;
    input [10:0] cnt;
    input [7:0] val;
    begin
      free_hit = (val != 8'h00) && (cnt == {val, 3'b000});
    end
  endfunction

  unit_ticker ticker (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .prescale_in(clock_prescaler),
    .fine_in(prescale_resolution),
    .tick_out(time_unit)
  );

  line_sync sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .line_in(line_in),
    .level_out(level),
    .fall_out(fall),
    .rise_out(rise)
  );

  // Bus decode, single wait-free access phase
  assign idx = paddr_in[17:2];
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in;
  assign rd = acc && !pwrite_in;
  assign wd = pwdata_in[7:0];
  assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in[31:18] == 14'h0000) &&
    (idx == `IDX_CLOCK_PRESCALER || idx == `IDX_TX_FREE_TIME ||
     idx == `IDX_MIN_EDGE_GAP || idx == `IDX_LOW_TIMEOUT ||
     idx == `IDX_RX_FREE_TIME || idx == `IDX_TX_START_DUTY ||
     idx == `IDX_BUS_FREE_CTRL || idx == `IDX_IRQ_STATUS ||
     idx == `IDX_IRQ_MASK || idx == `IDX_FRAME_CTRL);
  assign wr_bfc = wr && mapped && idx == `IDX_BUS_FREE_CTRL;
  assign wr_st = wr && mapped && idx == `IDX_IRQ_STATUS;

  assign rx_free_hit = time_unit && level &&
    free_hit(high_count, {1'b0, rx_free_time[6:0]});
  assign tx_free_hit = time_unit && level &&
    free_hit(tx_free_count, tx_free_time);

  assign bfc_read = {tx_bus_free_flag, tx_free_irq_en, rx_bus_free_flag,
    rx_free_irq_en, tx_free_irq_flag, rx_free_irq_flag, start_pulse_error,
    prescale_resolution};
  assign status = {start_pulse_error, rx_free_irq_flag, tx_free_irq_flag,
    timeout_flag, line_error_flag};

  // Read mux; write-only registers read zero
  always @* begin
    next_rdata = 8'h00;
    case (idx)
      `IDX_CLOCK_PRESCALER: next_rdata = clock_prescaler;
      `IDX_TX_FREE_TIME: next_rdata = tx_free_count[10:3];
      `IDX_MIN_EDGE_GAP: next_rdata = min_edge_gap;
      `IDX_LOW_TIMEOUT: next_rdata = low_timeout_limit;
      `IDX_RX_FREE_TIME: next_rdata = 8'h00;
      `IDX_TX_START_DUTY: next_rdata = 8'h00;
      `IDX_BUS_FREE_CTRL: next_rdata = bfc_read;
      `IDX_IRQ_STATUS: next_rdata = {3'b000, status};
      `IDX_IRQ_MASK: next_rdata = {3'b000, irq_mask};
      `IDX_FRAME_CTRL: next_rdata = bit_period;
      default: next_rdata = 8'h00;
    endcase
  end

  // APB answer, ready in the first access cycle
  always @(posedge clk_in) begin
    if (reset_in) begin
      prdata_out <= 32'h00000000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !mapped;
      prdata_out <= (psel_in && !penable_in && !pwrite_in && mapped) ?
        {24'h000000, next_rdata} : 32'h00000000;
    end
  end

  // Configuration register writes; rx free time and start duty are write-only
  always @(posedge clk_in) begin
    if (reset_in) begin
      clock_prescaler <= `REG_RESET;
      tx_free_time <= `REG_RESET;
      min_edge_gap <= `REG_RESET;
      low_timeout_limit <= `REG_RESET;
      rx_free_time <= `REG_RESET;
      tx_start_low_duty <= `REG_RESET;
      tx_free_irq_en <= 1'b0;
      rx_free_irq_en <= 1'b0;
      prescale_resolution <= 1'b0;
      irq_mask <= {`ST_WIDTH{1'b0}};
      bit_period <= `REG_RESET;
    end else if (wr && mapped) begin
      case (idx)
        `IDX_CLOCK_PRESCALER: clock_prescaler <= wd;
        `IDX_TX_FREE_TIME: tx_free_time <= wd;
        `IDX_MIN_EDGE_GAP: min_edge_gap <= wd;
        `IDX_LOW_TIMEOUT: low_timeout_limit <= wd;
        `IDX_RX_FREE_TIME: rx_free_time <= wd;
        `IDX_TX_START_DUTY: tx_start_low_duty <= wd;
        `IDX_BUS_FREE_CTRL: begin
          tx_free_irq_en <= wd[`BIT_TX_IRQ_EN];
          rx_free_irq_en <= wd[`BIT_RX_IRQ_EN];
          prescale_resolution <= wd[`BIT_RESOLUTION];
        end
        `IDX_IRQ_MASK: irq_mask <= wd[`ST_WIDTH-1:0];
        `IDX_FRAME_CTRL: bit_period <= wd;
        default: bit_period <= bit_period;
      endcase
    end
  end

  // Edge gap and bit counting; ninth bit ends timeout watch
  always @(posedge clk_in) begin
    if (reset_in) begin
      gap_count <= 16'h0000;
      seen_fall <= 1'b0;
      bits_done <= 4'h0;
      bit_count <= 8'h00;
      low_count <= 8'h00;
    end else begin
      if (fall) begin
        gap_count <= 16'h0000;
        seen_fall <= 1'b1;
        bit_count <= 8'h00;
        if (seen_fall && bits_done < `FRAME_BITS)
          bits_done <= bits_done + 4'h1;
      end else if (time_unit && gap_count != 16'hFFFF) begin
        gap_count <= gap_count + 16'h0001;
        if (seen_fall && bit_count == bit_period && bit_period != 8'h00) begin
          bit_count <= 8'h00;
          if (bits_done < `FRAME_BITS)
            bits_done <= bits_done + 4'h1;
        end else begin
          bit_count <= bit_count + 8'h01;
        end
      end
      // Frame over once line idles free, restart counting
      if (rx_free_hit || timeout_fire) begin
        seen_fall <= 1'b0;
        bits_done <= 4'h0;
      end
      // Low-level timer for timeout
      if (level)
        low_count <= 8'h00;
      else if (time_unit && low_count != 8'hFF)
        low_count <= low_count + 8'h01;
    end
  end

  assign gap_short = fall && seen_fall &&
    gap_count < {8'h00, min_edge_gap};
  assign timeout_fire = time_unit && !level && seen_fall &&
    bits_done < `FRAME_BITS && low_timeout_limit != 8'h00 &&
    low_count + 8'h01 == low_timeout_limit;

  // Bus-free counters in time units, saturating
  always @(posedge clk_in) begin
    if (reset_in) begin
      high_count <= 11'h000;
      tx_free_count <= 11'h000;
    end else begin
      if (fall || rise)
        high_count <= 11'h000;
      else if (time_unit && level && high_count != 11'h7FF)
        high_count <= high_count + 11'h001;
      if (fall)
        tx_free_count <= 11'h000;
      else if (time_unit && level && tx_free_count != 11'h7FF)
        tx_free_count <= tx_free_count + 11'h001;
    end
  end

  // Sticky flags, a set wins over a clear in the same cycle
  always @(posedge clk_in) begin
    if (reset_in) begin
      line_error_flag <= 1'b0;
      timeout_flag <= 1'b0;
      tx_bus_free_flag <= 1'b0;
      rx_bus_free_flag <= 1'b0;
      tx_free_irq_flag <= 1'b0;
      rx_free_irq_flag <= 1'b0;
      start_pulse_error <= 1'b0;
    end else begin
      if (gap_short)
        line_error_flag <= 1'b1;
      else if (wr_st && wd[`ST_LINE_ERR])
        line_error_flag <= 1'b0;
      if (timeout_fire)
        timeout_flag <= 1'b1;
      else if ((wr_st && wd[`ST_TIMEOUT]) || fall)
        timeout_flag <= 1'b0;
      // Read-only flag, hardware clear only
      if (tx_free_hit)
        tx_bus_free_flag <= 1'b1;
      else if (fall)
        tx_bus_free_flag <= 1'b0;
      if (rx_free_hit)
        rx_bus_free_flag <= 1'b1;
      else if ((wr_bfc && !wd[`BIT_RX_FREE]) || fall || rise)
        rx_bus_free_flag <= 1'b0;
      // Zero written clears, as in control register; one-write in status
      if (tx_free_hit)
        tx_free_irq_flag <= 1'b1;
      else if ((wr_bfc && !wd[`BIT_TX_IRQ_FLAG]) ||
          (wr_st && wd[`ST_TX_FREE]))
        tx_free_irq_flag <= 1'b0;
      if (rx_free_hit)
        rx_free_irq_flag <= 1'b1;
      else if ((wr_bfc && !wd[`BIT_RX_IRQ_FLAG]) ||
          (wr_st && wd[`ST_RX_FREE]))
        rx_free_irq_flag <= 1'b0;
      if (state == S_LOW && time_unit && level)
        start_pulse_error <= 1'b1;
      else if ((wr_bfc && !wd[`BIT_START_ERR]) ||
          (wr_st && wd[`ST_START_ERR]))
        start_pulse_error <= 1'b0;
    end
  end

  // Start pulse: hold line low for the start duty in units
  always @(posedge clk_in) begin
    if (reset_in) begin
      state <= S_IDLE;
      duty_count <= 8'h00;
      line_oe_out <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          duty_count <= 8'h00;
          if (start_req_in && tx_start_low_duty != 8'h00) begin
            state <= S_LOW;
            line_oe_out <= 1'b1;
          end
        end
        S_LOW: begin
          if (timeout_fire) begin
            state <= S_IDLE;
            line_oe_out <= 1'b0;
          end else if (time_unit) begin
            if (duty_count + 8'h01 >= tx_start_low_duty) begin
              state <= S_IDLE;
              line_oe_out <= 1'b0;
            end else begin
              duty_count <= duty_count + 8'h01;
            end
          end
        end
        default: begin
          state <= S_IDLE;
          line_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // Pulses and interrupt; enables gate the bus-free sources
  always @(posedge clk_in) begin
    if (reset_in) begin
      line_o_out <= 1'b0;
      frame_abort_out <= 1'b0;
      rx_idle_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      line_o_out <= 1'b0;
      frame_abort_out <= timeout_fire;
      rx_idle_out <= rx_free_hit && rx_free_time[7];
      irq_out <= |(status & irq_mask & {1'b1, rx_free_irq_en,
        tx_free_irq_en, 2'b11});
    end
  end
endmodule
`default_nettype wire

//--- core/line_monitor_map.vh
// Purpose: constants for the single-wire line timing monitor
// Assumes: 125 MHz clock, APB with 32-bit data, byte address = 4 x index
// Notes: printed offsets are not word aligned, so they are indices
// Function
// - Flag a line error when two falls come closer than min gap x unit.
// - Timeout checking runs only until nine bit periods of a frame complete.
// - A low level lasting the timeout limit x unit sets timeout and aborts.
// - The rx idle return bit sends the receiver back to idle for next frame.
// - Rx bus free sets after the line is high for 8 x rx free time bits 6:0 x unit.
// - Rx bus free clears on a written zero or on any line transition.
// - Tx bus free sets at 8 x tx free time x unit, cleared by a falling edge.
// - Tx free interrupt flag sets likewise, clears by a zero write or a one written to status.
// - Tx and rx free enable bits gate the interrupt, one enables.
// - Start pulse low duty comes from a write-only value in time units.
// - Time unit is clock over 2 x prescaler, or over prescaler if fine.
`ifndef LINE_MONITOR_MAP_VH
`define LINE_MONITOR_MAP_VH
`define IDX_CLOCK_PRESCALER 16'hA082
`define IDX_TX_FREE_TIME 16'hA089
`define IDX_MIN_EDGE_GAP 16'hA08C
`define IDX_LOW_TIMEOUT 16'hA08D
`define IDX_RX_FREE_TIME 16'hA08E
`define IDX_TX_START_DUTY 16'hA08F
`define IDX_BUS_FREE_CTRL 16'hA097
`define IDX_IRQ_STATUS 16'hA0A0
`define IDX_IRQ_MASK 16'hA0A1
`define IDX_FRAME_CTRL 16'hA0A2
`define BIT_TX_FREE 7
`define BIT_TX_IRQ_EN 6
`define BIT_RX_FREE 5
`define BIT_RX_IRQ_EN 4
`define BIT_TX_IRQ_FLAG 3
`define BIT_RX_IRQ_FLAG 2
`define BIT_START_ERR 1
`define BIT_RESOLUTION 0
`define ST_LINE_ERR 0
`define ST_TIMEOUT 1
`define ST_TX_FREE 2
`define ST_RX_FREE 3
`define ST_START_ERR 4
`define ST_WIDTH 5
`define REG_RESET 8'h00
`define FRAME_BITS 4'h9
`define FREE_SCALE 3
`endif

//--- core/line_sync.v
// Purpose: three-stage synchroniser with edge detect for the line pin
// Assumes: line idles high
// Notes: level changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  input wire clk_in, // System clock
  input wire reset_in, // Synchronous reset
  input wire line_in, // Raw pin level
  output reg level_out, // Filtered level
  output wire fall_out, // Falling edge pulse
  output wire rise_out // Rising edge pulse
);
  reg s1;
  reg s2;
  reg s3;
  // First stage only feeds second
  always @(posedge clk_in) begin
    if (reset_in) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level_out <= 1'b1;
    end else begin
      s1 <= line_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level_out <= s3;
    end
  end
  // Edges from agreed stages against held level
  assign fall_out = (s2 == s3) && !s3 && level_out;
  assign rise_out = (s2 == s3) && s3 && !level_out;
endmodule
`default_nettype wire

//--- core/unit_ticker.v
// Purpose: time unit tick generator
// Assumes: prescaler zero gives no tick
// Notes: divisor = prescaler, doubled when resolution clear
`timescale 1ns/1ps
`default_nettype none
module unit_ticker (
  input wire clk_in, // System clock
  input wire reset_in, // Synchronous reset
  input wire [7:0] prescale_in, // Divider value
  input wire fine_in, // Resolution select
  output reg tick_out // One-cycle unit tick
);
  reg [8:0] count;
  wire [8:0] divisor;
  // Divisor from prescaler and resolution
  assign divisor = fine_in ? {1'b0, prescale_in} : {prescale_in, 1'b0};
  always @(posedge clk_in) begin
    if (reset_in) begin
      count <= 9'h000;
      tick_out <= 1'b0;
    end else if (divisor == 9'h000) begin
      count <= 9'h000;
      tick_out <= 1'b0;
    end else if (count >= divisor - 9'h001) begin
      count <= 9'h000;
      tick_out <= 1'b1;
    end else begin
      count <= count + 9'h001;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- dv/line_monitor_chk.sv
// Purpose: port checker for the line monitor
// Assumes: APB answer in the first access cycle
// Notes: bound to every line_monitor instance
`timescale 1ns/1ps
`default_nettype none
`include "line_monitor_map.vh"
module line_monitor_chk (
  input wire clk_in, // Clock
  input wire reset_in, // Reset
  input wire psel_in, // Select
  input wire penable_in, // Enable
  input wire pwrite_in, // Direction
  input wire [31:0] paddr_in, // Address
  input wire [31:0] prdata_out, // Read data
  input wire pready_out, // Ready
  input wire pslverr_out, // Error
  input wire line_oe_out, // Line pull
  input wire line_o_out, // Line level
  input wire frame_abort_out, // Abort pulse
  input wire rx_idle_out, // Idle pulse
  input wire irq_out // Interrupt
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Bus phases
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    pready_out ##1 !pready_out;
  endsequence
  sequence s_wo_read;
    s_setup ##0 (!pwrite_in && (paddr_in[17:2] == `IDX_RX_FREE_TIME ||
      paddr_in[17:2] == `IDX_TX_START_DUTY));
  endsequence
  AST_APB_ANSWER: assert property (s_setup |=> s_answer)
    else $error("ready missing after setup");
  AST_READY_IN_ACCESS: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access phase");
  AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_RDATA_QUIET: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  AST_RDATA_BYTE: assert property (prdata_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_WO_ZERO: assert property (s_wo_read |=> prdata_out == 32'h0)
    else $error("write-only register read nonzero");
  AST_DRIVE_LOW: assert property (line_o_out == 1'b0)
    else $error("line driven high");
  AST_ABORT_PULSE: assert property (frame_abort_out |=> !frame_abort_out)
    else $error("abort longer than one cycle");
  AST_IDLE_PULSE: assert property ($rose(rx_idle_out) |=>
    $fell(rx_idle_out))
    else $error("idle return longer than one cycle");
  AST_RESET_QUIET: assert property ($fell(reset_in) |-> !irq_out &&
    !line_oe_out && !frame_abort_out && !pready_out)
    else $error("output active after reset");
endmodule
bind line_monitor line_monitor_chk line_monitor_chk_i (.clk_in(clk_in),
  .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .line_oe_out(line_oe_out), .line_o_out(line_o_out),
  .frame_abort_out(frame_abort_out), .rx_idle_out(rx_idle_out),
  .irq_out(irq_out));
`default_nettype wire

//--- dv/line_node.sv
// Purpose: remote node on the shared line, with the line pull-up
// Assumes: open-drain line, released line reads high
// Notes: the bench decides when the remote node pulls low
`timescale 1ns/1ps
`default_nettype none
module line_node (
  input wire logic pull_in, // Remote node pulls low
  input wire logic oe_in, // Monitor pulls low
  input wire logic o_in, // Monitor drive level
  output wire logic line_out // Resolved line level
);
  // Wired-AND; the pull-up wins whenever nobody drives
  assign line_out = ~((oe_in & ~o_in) | pull_in);
endmodule
`default_nettype wire

//--- dv/test_line_monitor.sv
// Purpose: self-checking bench for the line monitor
// Assumes: prescaler 1, so one time unit is 2 clocks (1 when fine)
// Notes: sync latency makes edge timing loose by a few clocks
`timescale 1ns/1ps
`default_nettype none
`include "line_monitor_map.vh"
module test_line_monitor;
  logic clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, start_req_in = 0, pull = 0, err;
  logic [31:0] paddr_in = 0, pwdata_in = 0, rd;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, line_in, line_oe_out, line_o_out;
  wire frame_abort_out, rx_idle_out, irq_out;
  int miscompares = 0, comparisons = 0, aborts = 0, idles = 0, oe_len = 0;
  logic [15:0] ids [4] = '{`IDX_MIN_EDGE_GAP, `IDX_LOW_TIMEOUT,
    `IDX_RX_FREE_TIME, `IDX_TX_START_DUTY};
  line_monitor line_monitor_i (.clk_in(clk_in), .reset_in(reset_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .line_in(line_in),
    .line_oe_out(line_oe_out), .line_o_out(line_o_out),
    .start_req_in(start_req_in), .frame_abort_out(frame_abort_out),
    .rx_idle_out(rx_idle_out), .irq_out(irq_out));
  line_node line_node_i (.pull_in(pull), .oe_in(line_oe_out),
    .o_in(line_o_out), .line_out(line_in));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  // Pulse and pull-time tallies
  always @(posedge clk_in) begin
    if (frame_abort_out === 1'b1) aborts <= aborts + 1;
    if (rx_idle_out === 1'b1) idles <= idles + 1;
    if (line_oe_out === 1'b1) oe_len <= oe_len + 1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Line error expected when the fall gap in clocks is under gap units;
  // assumes the coarse unit of two clocks
  function automatic logic [31:0] exp_gap_err(input int clks, input int gap);
    return {31'h0, clks < 2 * gap};
  endfunction
  task complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Held until ready is sampled; no cycle count assumed
  task apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= {14'h0, idx, 2'h0};
    pwdata_in <= {24'h0, wd};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      complete_run;
    end
  endtask
  task rc(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd & m, e);
  endtask
  task low(input int n, input int h);
    pull <= 1'b1;
    cyc(n);
    pull <= 1'b0;
    cyc(h);
  endtask
  task rst(input logic [7:0] tmo);
    reset_in <= 1'b1;
    cyc(8);
    reset_in <= 1'b0;
    apb(1'b1, `IDX_CLOCK_PRESCALER, 8'h01);
    apb(1'b1, `IDX_FRAME_CTRL, 8'h1E);
    apb(1'b1, `IDX_LOW_TIMEOUT, tmo);
  endtask
  initial begin
    int g;
    logic [7:0] v;
    g = $urandom(5);
    // Timeout of 35 units stays above the nominal low limit at 30-unit bits
    rst(8'h23);
    // Reset values, refused and write-only places
    for (int i = 0; i < 4; i++)
      rc(ids[i], 32'hFF, {24'h0, i == 1 ? 8'h23 : 8'h00});
    rc(`IDX_BUS_FREE_CTRL, 32'hFF, 32'h0);
    apb(1'b0, 16'hA0FF, 8'h00);
    chk({31'h0, err}, 32'h1);
    v = $urandom;
    apb(1'b1, `IDX_MIN_EDGE_GAP, v);
    rc(`IDX_MIN_EDGE_GAP, 32'hFF, {24'h0, v});
    apb(1'b1, `IDX_RX_FREE_TIME, v);
    rc(`IDX_RX_FREE_TIME, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, `IDX_MIN_EDGE_GAP, 8'h00);
    $display("test registers done");
    g = aborts;
    low(80, 20);
    rc(`IDX_IRQ_STATUS, 32'h2, 32'h2);
    chk(aborts - g, 1);
    $display("test timeout done");
    // Fresh frame: ten bits at 30 units, then a long low past bit nine
    rst(8'h23);
    for (int i = 0; i < 10; i++) low(4, 56);
    low(80, 20);
    rc(`IDX_IRQ_STATUS, 32'h2, 32'h0);
    apb(1'b1, `IDX_LOW_TIMEOUT, 8'h00);
    $display("test frame end done");
    apb(1'b1, `IDX_MIN_EDGE_GAP, 8'h14);
    low(4, 120);
    for (int i = 0; i < 8; i++) begin
      g = ($urandom & 1) ? $urandom_range(6, 30) : $urandom_range(50, 90);
      apb(1'b1, `IDX_IRQ_STATUS, 8'h1F);
      low(4, g - 4);
      low(4, 120);
      rc(`IDX_IRQ_STATUS, 32'h1, exp_gap_err(g, 20));
    end
    cyc(2);
    chk(irq_out, 0);
    apb(1'b1, `IDX_IRQ_MASK, 8'h01);
    cyc(2);
    chk(irq_out, exp_gap_err(g, 20));
    apb(1'b1, `IDX_IRQ_STATUS, 8'h1F);
    cyc(2);
    chk(irq_out, 0);
    $display("test line error done");
    apb(1'b1, `IDX_TX_FREE_TIME, 8'h02);
    apb(1'b1, `IDX_BUS_FREE_CTRL, 8'h40);
    // Hit is an exact count match, so a fresh fall must restart the count
    low(4, 100);
    rc(`IDX_BUS_FREE_CTRL, 32'hC8, 32'hC8);
    apb(1'b1, `IDX_IRQ_MASK, 8'h04);
    cyc(2);
    chk(irq_out, 1);
    apb(1'b1, `IDX_BUS_FREE_CTRL, 8'h08);
    cyc(2);
    chk(irq_out, 0);
    apb(1'b1, `IDX_BUS_FREE_CTRL, 8'h48);
    pull <= 1'b1;
    cyc(6);
    rc(`IDX_BUS_FREE_CTRL, 32'hC8, 32'h48);
    apb(1'b1, `IDX_BUS_FREE_CTRL, 8'h40);
    rc(`IDX_BUS_FREE_CTRL, 32'h08, 32'h0);
    pull <= 1'b0;
    apb(1'b1, `IDX_IRQ_MASK, 8'h00);
    $display("test tx free done");
    apb(1'b1, `IDX_RX_FREE_TIME, 8'h82);
    apb(1'b1, `IDX_BUS_FREE_CTRL, 8'h10);
    g = idles;
    low(4, 100);
    rc(`IDX_BUS_FREE_CTRL, 32'h24, 32'h24);
    chk(idles - g, 1);
    apb(1'b1, `IDX_BUS_FREE_CTRL, 8'h10);
    rc(`IDX_BUS_FREE_CTRL, 32'h20, 32'h0);
    low(4, 100);
    pull <= 1'b1;
    cyc(6);
    rc(`IDX_BUS_FREE_CTRL, 32'h20, 32'h0);
    pull <= 1'b0;
    $display("test rx free done");
    apb(1'b1, `IDX_TX_START_DUTY, 8'h05);
    // Coarse then fine resolution; one clock of tick phase slack
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, `IDX_BUS_FREE_CTRL, {7'h0, r[0]});
      g = oe_len;
      start_req_in <= 1'b1;
      cyc(1);
      start_req_in <= 1'b0;
      cyc(40);
      g = oe_len - g - (r ? 5 : 10);
      chk({31'h0, g >= -1 && g <= 1}, 1);
    end
    $display("test start pulse done");
    complete_run;
  end
endmodule
`default_nettype wire
